// ==== logic/irl_top.sv ====
`timescale 1ns/1ps
module irl_top #(
  parameter int unsigned OSC_DIV = irl_pkg::OSC_DIV_CYC,
  parameter int unsigned SAMPLE_TICKS = irl_pkg::SAMPLE_OSC_CYC,
  parameter int unsigned SCAN_TICKS = irl_pkg::SCAN_OSC_CYC,
  parameter int unsigned WAKE_WAIT_CYC = irl_pkg::WAKE_WAIT_DEF,
  parameter int unsigned DB_SAMPLES = irl_pkg::DB_SAMPLE_CNT
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wake_input_pin,
  input wire logic ir_data_input_pin,
  input wire logic advance_button_input_n,
  input wire logic standby_button_input_n,
  output logic [7:0] segment_outputs,
  output logic digit_select_a,
  output logic digit_select_b,
  output logic active_mode
);
  localparam int unsigned CW = irl_pkg::CNT_W;

  irl_pkg::irl_state_e state_q;
  logic [CW-1:0] osc_cnt_q, samp_cnt_q, scan_cnt_q, wait_cnt_q;
  logic osc_tick, sample_tick, scan_tick, dec_on;
  logic wake_fall, ir_level, adv_press, stb_press;

  // ==========================================================
  // oscillator rate enable and periodic ticks
  assign osc_tick = (osc_cnt_q == CW'(OSC_DIV - 1));
  assign dec_on = (state_q == irl_pkg::ST_RECV) || (state_q == irl_pkg::ST_SHOW);
  assign sample_tick = osc_tick && (samp_cnt_q == CW'(SAMPLE_TICKS - 1));
  assign scan_tick = osc_tick && (scan_cnt_q == CW'(SCAN_TICKS - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_cnt_q <= '0;
    end else if (osc_tick) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_q + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      samp_cnt_q <= '0;
      scan_cnt_q <= '0;
    end else if (!dec_on) begin
      samp_cnt_q <= '0;
      scan_cnt_q <= '0;
    end else if (osc_tick) begin
      samp_cnt_q <= sample_tick ? '0 : samp_cnt_q + CW'(1);
      scan_cnt_q <= scan_tick ? '0 : scan_cnt_q + CW'(1);
    end
  end

  // ==========================================================
  // pin inputs; wake and data arrive on separate pins
  irl_sync u_wake (
    .sys_clk(sys_clk), .reset_n(reset_n), .tick(sample_tick),
    .pin(wake_input_pin), .level(), .fall(wake_fall));
  irl_sync u_data (
    .sys_clk(sys_clk), .reset_n(reset_n), .tick(sample_tick),
    .pin(ir_data_input_pin), .level(ir_level), .fall());
  // two button pins, each debounced on its own
  irl_sync #(.DB_SAMPLES(DB_SAMPLES)) u_adv (
    .sys_clk(sys_clk), .reset_n(reset_n), .tick(sample_tick),
    .pin(advance_button_input_n), .level(), .fall(adv_press));
  irl_sync #(.DB_SAMPLES(DB_SAMPLES)) u_stb (
    .sys_clk(sys_clk), .reset_n(reset_n), .tick(sample_tick),
    .pin(standby_button_input_n), .level(), .fall(stb_press));

  // ==========================================================
  // mode sequence
  logic buf_pop;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= irl_pkg::ST_STANDBY;
      wait_cnt_q <= '0;
    end else begin
      case (state_q)
        irl_pkg::ST_STANDBY: begin
          wait_cnt_q <= '0;
          if (wake_fall) begin
            state_q <= irl_pkg::ST_WAKE;
          end
        end
        irl_pkg::ST_WAKE: begin
          // no settle interval: the clock is supplied from outside
          if (osc_tick) begin
            if (wait_cnt_q == CW'(WAKE_WAIT_CYC - 1)) begin
              state_q <= irl_pkg::ST_RECV;
            end else begin
              wait_cnt_q <= wait_cnt_q + CW'(1);
            end
          end
        end
        irl_pkg::ST_RECV: begin
          if (stb_press) begin
            state_q <= irl_pkg::ST_STANDBY;
          end else if (buf_pop) begin
            state_q <= irl_pkg::ST_SHOW;
          end
        end
        irl_pkg::ST_SHOW: begin
          if (stb_press) begin
            state_q <= irl_pkg::ST_STANDBY;
          end
        end
        default: state_q <= irl_pkg::ST_STANDBY;
      endcase
    end
  end

  // ==========================================================
  // space-length decoder; a frame waiting on a full buffer stalls it
  logic prev_lvl_q, armed_q, fr_valid_q, buf_in_ready, buf_push, mark_start;
  logic [7:0] gap_q;
  logic [4:0] bit_cnt_q;
  logic [irl_pkg::FRAME_BITS-1:0] shreg_q;

  assign buf_push = fr_valid_q && buf_in_ready;
  assign mark_start = sample_tick && !fr_valid_q && prev_lvl_q && !ir_level;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_lvl_q <= 1'b1;
      armed_q <= 1'b0;
      fr_valid_q <= 1'b0;
      gap_q <= 8'h00;
      bit_cnt_q <= 5'h00;
      shreg_q <= '0;
    end else if (!dec_on) begin
      prev_lvl_q <= 1'b1;
      armed_q <= 1'b0;
      fr_valid_q <= 1'b0;
      gap_q <= 8'h00;
      bit_cnt_q <= 5'h00;
    end else begin
      if (buf_push) begin
        fr_valid_q <= 1'b0;
      end
      if (sample_tick && !fr_valid_q) begin
        prev_lvl_q <= ir_level;
        if (ir_level) begin
          if (gap_q != irl_pkg::IDLE_GAP) begin
            gap_q <= gap_q + 8'h01;
          end else begin
            armed_q <= 1'b0;
          end
        end else begin
          gap_q <= 8'h00;
        end
        if (mark_start) begin
          if (gap_q >= irl_pkg::LEADER_GAP_MIN) begin
            armed_q <= 1'b1;
            bit_cnt_q <= 5'h00;
          end else if (armed_q) begin
            // right shift puts the first bit at bit 0 of byte 0
            shreg_q <= {gap_q >= irl_pkg::ONE_GAP_MIN, shreg_q[31:1]};
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == irl_pkg::LAST_BIT) begin
              fr_valid_q <= 1'b1;
              armed_q <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // two-entry frame buffer
  irl_pkg::irl_frame_s buf_mem_q [2];
  logic wr_ptr_q, rd_ptr_q;
  logic [1:0] buf_cnt_q;
  logic buf_out_valid;

  assign buf_in_ready = (buf_cnt_q != 2'h2);
  assign buf_out_valid = (buf_cnt_q != 2'h0);
  assign buf_pop = buf_out_valid && (state_q == irl_pkg::ST_RECV) && !stb_press;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else if (!dec_on) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else begin
      if (buf_push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (buf_pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (buf_push) begin
      buf_mem_q[wr_ptr_q] <= irl_pkg::irl_frame_s'(shreg_q);
    end
  end

  // ==========================================================
  // byte selection and digit scan
  irl_pkg::irl_frame_s shown_q;
  logic [2:0] byte_idx_q;
  logic digit_q;
  logic [7:0] cur_byte;
  irl_pkg::irl_disp_s disp_d, disp_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shown_q <= '0;
      byte_idx_q <= 3'h0;
    end else if (buf_pop) begin
      shown_q <= buf_mem_q[rd_ptr_q];
      byte_idx_q <= 3'h0;
    end else if (state_q == irl_pkg::ST_SHOW && adv_press
                 && byte_idx_q != irl_pkg::BYTE_IDX_DASH) begin
      byte_idx_q <= byte_idx_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      digit_q <= 1'b0;
    end else if (!dec_on) begin
      digit_q <= 1'b0;
    end else if (scan_tick) begin
      digit_q <= ~digit_q;
    end
  end

  assign cur_byte = shown_q.bytes[byte_idx_q[1:0]];

  always_comb begin
    disp_d.sel_a = dec_on && !digit_q;
    disp_d.sel_b = dec_on && digit_q;
    if (!dec_on) begin
      disp_d.seg = irl_pkg::SEG_BLANK;
    end else if (state_q == irl_pkg::ST_RECV || byte_idx_q == irl_pkg::BYTE_IDX_DASH) begin
      disp_d.seg = irl_pkg::SEG_DASH;
    end else begin
      // digit a carries the high nibble
      disp_d.seg = irl_pkg::irl_hex_to_seg(digit_q ? cur_byte[3:0] : cur_byte[7:4]);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      disp_q <= '0;
    end else begin
      disp_q <= disp_d;
    end
  end

  assign segment_outputs = disp_q.seg;
  assign digit_select_a = disp_q.sel_a;
  assign digit_select_b = disp_q.sel_b;
  assign active_mode = dec_on;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic [31:0] since_samp_q;
  logic samp_seen_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      since_samp_q <= 32'h0;
      samp_seen_q <= 1'b0;
    end else begin
      since_samp_q <= sample_tick ? 32'h0 : since_samp_q + 32'h1;
      samp_seen_q <= dec_on && (samp_seen_q || sample_tick);
    end
  end

  one_digit_a: assert property ($past(dec_on) && dec_on |-> digit_select_a ^ digit_select_b)
    else $error("digit selects not one-hot while active");
  blank_standby_a: assert property (!dec_on && !$past(dec_on)
      |-> !digit_select_a && !digit_select_b && segment_outputs == irl_pkg::SEG_BLANK)
    else $error("display not blank in standby");
  wake_start_a: assert property (state_q == irl_pkg::ST_STANDBY && wake_fall
      |=> state_q == irl_pkg::ST_WAKE)
    else $error("wake edge did not start wake wait");
  wake_wait_a: assert property (state_q == irl_pkg::ST_RECV
      && $past(state_q) == irl_pkg::ST_WAKE
      |-> $past(wait_cnt_q) == CW'(WAKE_WAIT_CYC - 1) && $past(osc_tick))
    else $error("wake wait length wrong");
  sample_period_a: assert property (sample_tick && samp_seen_q
      |-> since_samp_q == OSC_DIV * SAMPLE_TICKS - 1)
    else $error("sample tick period wrong");
  scan_toggle_a: assert property (scan_tick && dec_on
      |=> ##1 (digit_select_a == $past(digit_select_b) || !dec_on))
    else $error("digit did not switch on scan tick");
  decode_bit_a: assert property (mark_start && armed_q
      && gap_q < irl_pkg::LEADER_GAP_MIN
      |=> shreg_q[31] == ($past(gap_q) >= irl_pkg::ONE_GAP_MIN))
    else $error("decoded bit wrong");
  buf_hold_a: assert property (fr_valid_q && !buf_in_ready && dec_on
      |=> fr_valid_q && $stable(shreg_q))
    else $error("frame lost while buffer full");
  advance_step_a: assert property (state_q == irl_pkg::ST_SHOW && adv_press && !buf_pop
      && byte_idx_q != irl_pkg::BYTE_IDX_DASH |=> byte_idx_q == $past(byte_idx_q) + 3'h1)
    else $error("advance did not step one byte");
  dash_shown_a: assert property (state_q == irl_pkg::ST_SHOW
      && $past(state_q) == irl_pkg::ST_SHOW && byte_idx_q == irl_pkg::BYTE_IDX_DASH
      && $past(byte_idx_q) == irl_pkg::BYTE_IDX_DASH
      |-> segment_outputs == irl_pkg::SEG_DASH)
    else $error("dash not shown after last byte");
  // top segment bit must stay low, so it is checked, not assumed
  seg_code_a: assert property (state_q == irl_pkg::ST_SHOW
      && $past(state_q) == irl_pkg::ST_SHOW && $stable(byte_idx_q)
      && byte_idx_q != irl_pkg::BYTE_IDX_DASH
      |-> segment_outputs == irl_pkg::irl_hex_to_seg(digit_select_a
          ? shown_q.bytes[byte_idx_q[1:0]][7:4] : shown_q.bytes[byte_idx_q[1:0]][3:0]))
    else $error("segment pattern wrong");
  standby_ret_a: assert property (dec_on && stb_press |=> state_q == irl_pkg::ST_STANDBY)
    else $error("standby press ignored");

  wake_to_recv_c: cover property (state_q == irl_pkg::ST_WAKE ##1 state_q == irl_pkg::ST_RECV);
  frame_push_c: cover property (buf_push);
  buf_full_c: cover property (fr_valid_q && !buf_in_ready);
  dash_c: cover property (state_q == irl_pkg::ST_SHOW && byte_idx_q == irl_pkg::BYTE_IDX_DASH);
endmodule : irl_top

// ==== common/irl_pkg.sv ====
// Notes on behaviour
// - in standby, the leading part of an ir burst raises the wake request
// - after wake, wait a set count of 16 to 13,072 clocks, then go active
// - clock is external, so no oscillator settle time is added to the wait
// - wake comes from the wake pin; ir data from its own data pin
// - once active, keep receiving the rest of the same transmission
// - sample the ir data line once every 0.1 ms on a timer tick
// - collect a 4 byte, 32 bit frame, each byte least significant bit first
// - show one byte at a time as two hex digits, FF down to 00
// - each advance press moves the display to the next byte
// - after the fourth byte, the next advance shows a dash on both digits
// - standby press after display returns to standby, awaiting a new burst
// - advance and standby buttons are read on two separate pins
// - digits light in turn, switching every 6.5536 ms timer overflow
// - two digit selects driven alternately, exactly one active at a time; in standby the code drives neither select
// - eight segment outputs are active high
// - hex 0-F map to 3F,06,5B,4F,66,6D,7D,27,7F,6F,77,7C,39,5E,79,71
// - all timing derives from a 10 MHz oscillator clock
package irl_pkg;
  // ==========================================================
  // clocks and timing
  localparam int unsigned SYS_CLK_HZ = 250_000_000;
  localparam int unsigned OSC_CLK_HZ = 10_000_000;
  localparam int unsigned OSC_DIV_CYC = SYS_CLK_HZ / OSC_CLK_HZ;
  localparam int unsigned SAMPLE_PERIOD_US = 100;
  localparam int unsigned SAMPLE_OSC_CYC = SAMPLE_PERIOD_US * (OSC_CLK_HZ / 1_000_000);
  localparam int unsigned SCAN_PERIOD_NS = 6_553_600;
  localparam int unsigned SCAN_OSC_CYC = SCAN_PERIOD_NS / (1_000_000_000 / OSC_CLK_HZ);
  localparam int unsigned WAKE_WAIT_MIN = 16;
  localparam int unsigned WAKE_WAIT_MAX = 13_072;
  localparam int unsigned WAKE_WAIT_DEF = 8_192;
  localparam int unsigned DB_SAMPLE_CNT = 200;
  localparam int unsigned CNT_W = 17;
  // ==========================================================
  // space lengths in sample ticks
  localparam logic [7:0] ONE_GAP_MIN = 8'h0c;
  localparam logic [7:0] LEADER_GAP_MIN = 8'h1e;
  localparam logic [7:0] IDLE_GAP = 8'h78;
  // ==========================================================
  // frame and display
  localparam int unsigned FRAME_BITS = 32;
  localparam logic [4:0] LAST_BIT = 5'h1f;
  localparam logic [2:0] BYTE_IDX_DASH = 3'h4;
  localparam logic [7:0] SEG_DASH = 8'h40;
  localparam logic [7:0] SEG_BLANK = 8'h00;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_WAKE = 2'b01,
    ST_RECV = 2'b10,
    ST_SHOW = 2'b11
  } irl_state_e;

  typedef struct packed {
    logic [3:0][7:0] bytes;
  } irl_frame_s;

  typedef struct packed {
    logic [7:0] seg;
    logic sel_a;
    logic sel_b;
  } irl_disp_s;

  function automatic logic [7:0] irl_hex_to_seg(input logic [3:0] nib);
    logic [7:0] s;
    s = 8'h00;
    case (nib)
      4'h0: s = 8'h3f;
      4'h1: s = 8'h06;
      4'h2: s = 8'h5b;
      4'h3: s = 8'h4f;
      4'h4: s = 8'h66;
      4'h5: s = 8'h6d;
      4'h6: s = 8'h7d;
      4'h7: s = 8'h27;
      4'h8: s = 8'h7f;
      4'h9: s = 8'h6f;
      4'ha: s = 8'h77;
      4'hb: s = 8'h7c;
      4'hc: s = 8'h39;
      4'hd: s = 8'h5e;
      4'he: s = 8'h79;
      4'hf: s = 8'h71;
      default: s = 8'h00;
    endcase
    return s;
  endfunction : irl_hex_to_seg
endpackage : irl_pkg

// ==== logic/irl_sync.sv ====
`timescale 1ns/1ps
module irl_sync #(
  parameter int unsigned DB_SAMPLES = 0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic pin,
  output logic level,
  output logic fall
);
  // ==========================================================
  // three stage synchroniser, stage one read only by stage two
  logic ff1_q, ff2_q, ff3_q, stable_q, fall_q;
  logic [15:0] db_cnt_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ff1_q <= 1'b1;
      ff2_q <= 1'b1;
      ff3_q <= 1'b1;
    end else begin
      ff1_q <= pin;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
    end
  end

  // ==========================================================
  // a change counts once stages two and three agree, held for the debounce span
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stable_q <= 1'b1;
      fall_q <= 1'b0;
      db_cnt_q <= 16'h0000;
    end else begin
      fall_q <= 1'b0;
      if (ff2_q != ff3_q || ff3_q == stable_q) begin
        db_cnt_q <= 16'h0000;
      end else if (DB_SAMPLES == 0) begin
        stable_q <= ff3_q;
        fall_q <= ~ff3_q;
      end else if (tick) begin
        if (db_cnt_q == 16'(DB_SAMPLES - 1)) begin
          stable_q <= ff3_q;
          fall_q <= ~ff3_q;
          db_cnt_q <= 16'h0000;
        end else begin
          db_cnt_q <= db_cnt_q + 16'h0001;
        end
      end
    end
  end

  assign level = stable_q;
  assign fall = fall_q;
endmodule : irl_sync

// ==== tb/irl_remote.sv ====
`timescale 1ns/1ps
// ==========================================================
// remote transmitter, receiver module and two push-buttons
module irl_remote #(
  parameter int unsigned SAMPLE_CYC = 20
) (
  input wire logic sys_clk,
  output logic ir_n,
  output logic adv_n,
  output logic stby_n
);
  // receiver output and buttons idle high through their pull-ups
  initial begin
    ir_n = 1'b1;
    adv_n = 1'b1;
    stby_n = 1'b1;
  end

  // ==========================================================
  // demodulated line: low = carrier burst, high = space
  task automatic level_for(input logic lvl, input int unsigned n);
    ir_n = lvl;
    repeat (n * SAMPLE_CYC) @(negedge sys_clk);
  endtask : level_for

  // second and fourth bytes are sent inverted, bytes go lsb first
  task automatic send_frame(input logic [7:0] a, input logic [7:0] c);
    logic [31:0] w;
    w = {~c, c, ~a, a};
    @(negedge sys_clk);
    level_for(1'b0, 10);
    level_for(1'b1, 45);
    level_for(1'b0, 5);
    for (int i = 0; i < 32; i++) begin
      level_for(1'b1, w[i] ? 16 : 5);
      level_for(1'b0, 5);
    end
    ir_n = 1'b1;
  endtask : send_frame

  // ==========================================================
  // a press bounces once before it settles, so debounce is exercised
  task automatic set_btn(input logic stby, input logic v);
    if (stby) begin
      stby_n = v;
    end else begin
      adv_n = v;
    end
  endtask : set_btn

  task automatic press(input logic stby);
    @(negedge sys_clk);
    set_btn(stby, 1'b0);
    repeat (3) @(negedge sys_clk);
    set_btn(stby, 1'b1);
    repeat (3) @(negedge sys_clk);
    set_btn(stby, 1'b0);
    repeat (10 * SAMPLE_CYC) @(negedge sys_clk);
    set_btn(stby, 1'b1);
    repeat (10 * SAMPLE_CYC) @(negedge sys_clk);
  endtask : press
endmodule : irl_remote

// ==== tb/irl_top_tb.sv ====
`timescale 1ns/1ps
module irl_top_tb;
  // ==========================================================
  // shortened counts keep the run small; the wake, scan and frame timing checks derive from these
  localparam int unsigned D = 5;
  localparam int unsigned SMP = 4;
  localparam int unsigned SCAN = 8;
  localparam int unsigned WAIT = 16;
  localparam int unsigned DB = 2;
  localparam int unsigned SCYC = SMP * D;
  localparam int unsigned LIMIT = 80_000;
  localparam logic [7:0] SEG_TAB [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d,
    8'h27, 8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};

  logic sys_clk;
  logic reset_n;
  logic ir_n;
  logic adv_n;
  logic stby_n;
  logic [7:0] seg;
  logic sel_a;
  logic sel_b;
  logic act;
  int n_errors;
  int num_checks;
  int cyc;

  irl_top #(.OSC_DIV(D), .SAMPLE_TICKS(SMP), .SCAN_TICKS(SCAN), .WAKE_WAIT_CYC(WAIT),
    .DB_SAMPLES(DB)) uut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wake_input_pin(ir_n),
    .ir_data_input_pin(ir_n),
    .advance_button_input_n(adv_n),
    .standby_button_input_n(stby_n),
    .segment_outputs(seg),
    .digit_select_a(sel_a),
    .digit_select_b(sel_b),
    .active_mode(act)
  );

  // the model's default sample span already equals SMP * D
  irl_remote rem (
    .sys_clk(sys_clk),
    .ir_n(ir_n),
    .adv_n(adv_n),
    .stby_n(stby_n)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // compare and report
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  // hang guard: a limit reached counts as a mismatch
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      $display("BAD timeout expected finish seen %0d cycles", cyc);
      close_out();
    end
  end

  // ==========================================================
  // display helpers
  task automatic wait_sel(input logic a_side);
    for (int i = 0; i < 4 * SCAN * D; i++) begin
      @(negedge sys_clk);
      if ((a_side ? sel_a : sel_b) === 1'b1) break;
    end
    chk8("digit selects", a_side ? 8'h02 : 8'h01, {6'h00, sel_a, sel_b});
  endtask : wait_sel

  task automatic show_pair(input logic [7:0] hi, input logic [7:0] lo);
    wait_sel(1'b1);
    chk8("high digit", hi, seg);
    wait_sel(1'b0);
    chk8("low digit", lo, seg);
  endtask : show_pair

  task automatic show_byte(input logic [7:0] b);
    show_pair(SEG_TAB[b[7:4]], SEG_TAB[b[3:0]]);
  endtask : show_byte

  // ==========================================================
  // scenarios
  task automatic t_idle();
    chk8("reset outputs", 8'h00, {5'h00, sel_a, sel_b, act});
    chk8("reset segments", 8'h00, seg);
    rem.press(1'b0);
    rem.press(1'b1);
    chk8("buttons in standby", 8'h00, {7'h00, act});
    $display("test idle done");
  endtask : t_idle

  task automatic measure_wake();
    int n;
    n = 0;
    for (int i = 0; i < 200 && ir_n !== 1'b0; i++) @(posedge sys_clk);
    chk8("standby before wake", 8'h00, {7'h00, act});
    while (act !== 1'b1 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    chk_rng("wake delay", (WAIT - 1) * D, WAIT * D + D + 8, n);
  endtask : measure_wake

  // leader mark still running at wake, rest of frame must be caught
  task automatic t_frame(input logic [7:0] a, input logic [7:0] c);
    fork
      rem.send_frame(a, c);
      measure_wake();
    join
    repeat (3 * SCYC) @(negedge sys_clk);
    show_byte(a);
    rem.press(1'b0);
    show_byte(~a);
    rem.press(1'b0);
    show_byte(c);
    rem.press(1'b0);
    show_byte(~c);
    rem.press(1'b0);
    show_pair(8'h40, 8'h40);
    rem.press(1'b0);
    show_pair(8'h40, 8'h40);
    $display("test frame %h %h done", a, c);
  endtask : t_frame

  task automatic t_scan();
    int n;
    n = 0;
    wait_sel(1'b0);
    wait_sel(1'b1);
    while (sel_a === 1'b1 && n < 4 * SCAN * D) begin
      @(negedge sys_clk);
      n++;
    end
    chk_rng("scan period", SCAN * D, SCAN * D, n);
    $display("test scan done");
  endtask : t_scan

  task automatic t_standby();
    rem.press(1'b1);
    chk8("after standby press", 8'h00, {7'h00, act});
    $display("test standby done");
  endtask : t_standby

  // ==========================================================
  // two frames between them light all sixteen hex digits
  initial begin
    reset_n = 1'b0;
    n_errors = 0;
    num_checks = 0;
    cyc = 0;
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    t_idle();
    t_frame(8'h50, 8'h17);
    t_scan();
    t_standby();
    t_frame(8'hb3, 8'hd6);
    t_standby();
    close_out();
  end
endmodule : irl_top_tb
